// ### design/flp_arbiter.sv
// Priority and natural-order arbiter
`include "flp_defs.svh"
module flp_arbiter import flp_pkg::*; #(
	parameter int NSRC = `FLP_NSRC
) (
	// Requests
	input wire logic [NSRC-1:0] i_req,
	input wire logic [NSRC-1:0] i_hi_bits,
	input wire logic [NSRC-1:0] i_lo_bits,
	// Winner
	output logic o_valid,
	output logic [3:0] o_idx,
	output flp_level_t o_level
);
	always_comb begin
		o_valid = 1'b0;
		o_idx = 4'd0;
		o_level = `FLP_LVL_NONE;
		// Descending scan: lower index wins ties
		for (int i = NSRC - 1; i >= 0; i--) begin
			flp_level_t lv;
			lv = (i == 0) ? `FLP_LVL_PF : {1'b0, i_hi_bits[i], i_lo_bits[i]};
			if (i_req[i] && (!o_valid || lv >= o_level)) begin
				o_valid = 1'b1;
				o_idx = i[3:0];
				o_level = lv;
			end
		end
	end
endmodule : flp_arbiter

// ### design/flp_defs.svh
// Constants and functional notes for the five-level interrupt prioritizer
// Functional notes
// - Five levels 4..0, level 4 power-fail only
// - Other sources programmable to levels 3..0
// - Enabled pending power-fail always wins
// - Equal levels resolved by fixed natural order
// - Flags set regardless of any enable
// - Accepted source branches to its fixed vector
// - Edge-mode ext0/1 flag cleared on vectoring
// - Level-mode ext0/1 flag follows the pin
// - Timer 0/1 flags cleared on vectoring
// - Serial and timer 2 merge two flags
// - Priority bits share position in register pair
// - Global enable off blocks all but power-fail
// - Power-fail gated only by own enable
`ifndef FLP_DEFS_SVH
`define FLP_DEFS_SVH
`define FLP_NSRC 13
`define FLP_PF 4'd0
`define FLP_X0 4'd1
`define FLP_T0 4'd2
`define FLP_X1 4'd3
`define FLP_T1 4'd4
`define FLP_S0 4'd5
`define FLP_T2 4'd6
`define FLP_S1 4'd7
`define FLP_X2 4'd8
`define FLP_WD 4'd12
`define FLP_LVL_PF 3'd4
`define FLP_LVL_NONE 3'd0
`define FLP_VEC_TABLE {8'h63, 8'h5b, 8'h53, 8'h4b, 8'h43, 8'h3b, 8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03, 8'h33}
`define FLP_VEC_X0 8'h03
`define FLP_VEC_T0 8'h0b
`define FLP_VEC_X1 8'h13
`define FLP_VEC_T1 8'h1b
// AXI register byte addresses
`define FLP_A_CTRL 8'h00
`define FLP_A_IE 8'h04
`define FLP_A_EIE 8'h08
`define FLP_A_PLO 8'h0c
`define FLP_A_PHI 8'h10
`define FLP_A_EPLO 8'h14
`define FLP_A_EPHI 8'h18
`define FLP_A_FLAGS 8'h1c
`define FLP_A_FCLR 8'h20
`define FLP_A_STAT 8'h24
`define FLP_A_ACK 8'h28
`define FLP_A_RETI 8'h2c
`define FLP_A_EVST 8'h30
`define FLP_A_EVCLR 8'h34
`define FLP_A_EVEN 8'h38
`define FLP_RESP_OK 2'b00
`define FLP_RESP_ERR 2'b10
`endif

// ### design/flp_intc.sv
// Five-level interrupt prioritizer with AXI4-Lite register access
`include "flp_defs.svh"
module flp_intc import flp_pkg::*; #(
	parameter int NSRC = `FLP_NSRC
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Source events
	input wire logic I_POWERFAIL_EVT,
	input wire logic I_EXT0_PIN_N,
	input wire logic I_EXT1_PIN_N,
	input wire logic I_TMR0_OVF,
	input wire logic I_TMR1_OVF,
	input wire logic I_TMR2_OVF,
	input wire logic I_TMR2_EXT,
	input wire logic I_SER0_RX,
	input wire logic I_SER0_TX,
	input wire logic I_SER1_RX,
	input wire logic I_SER1_TX,
	input wire logic [3:0] I_EXT25_EVT,
	input wire logic I_WDOG_EVT,
	// Core interface
	output logic O_IRQ_REQ,
	output logic [7:0] O_IRQ_VECTOR,
	output logic [2:0] O_IRQ_LEVEL,
	output logic O_EVT_IRQ,
	// AXI4-Lite write
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// AXI4-Lite read
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic global_irq_enable_ff, powerfail_irq_enable_ff, ext0_edge_ff, ext1_edge_ff;
	logic [7:0] ie_ff, ext_irq_enable_reg_ff;
	logic [7:0] priority_low_bits_ff, priority_high_bits_ff;
	logic [4:0] ext_priority_low_bits_ff, ext_priority_high_bits_ff;
	logic powerfail_flag_ff, ext0_flag_ff, ext1_flag_ff, tmr0_overflow_flag_ff, tmr1_overflow_flag_ff;
	logic tmr2_overflow_flag_ff, tmr2_external_flag_ff, ser0_receive_flag_ff, ser0_transmit_flag_ff;
	logic ser1_receive_flag_ff, ser1_transmit_flag_ff, wdog_irq_flag_ff;
	logic [3:0] ext25_flag_ff;
	logic ext0_pin_d_ff, ext1_pin_d_ff;
	logic [4:0] active_ff;
	logic [1:0] evt_status_ff, evt_enable_ff;
	logic [7:0] awaddr_ff, araddr_ff;
	logic aw_have_ff, w_have_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff, rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [7:0] irq_vector_ff;
	logic [2:0] irq_level_ff;
	logic irq_req_ff;

	////////////////////////////////////////////////////////////////////////////////
	// AXI write channel
	logic wr_go, wr_ok, ack_wr, reti_wr, rd_go;
	logic [31:0] wd;
	assign O_AWREADY = !aw_have_ff && !bvalid_ff;
	assign O_WREADY = !w_have_ff && !bvalid_ff;
	assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
	assign wd = wdata_ff & {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	always_comb begin
		unique case (awaddr_ff)
			`FLP_A_CTRL, `FLP_A_IE, `FLP_A_EIE, `FLP_A_PLO, `FLP_A_PHI, `FLP_A_EPLO, `FLP_A_EPHI,
			`FLP_A_FLAGS, `FLP_A_FCLR, `FLP_A_STAT, `FLP_A_ACK, `FLP_A_RETI, `FLP_A_EVST,
			`FLP_A_EVCLR, `FLP_A_EVEN: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `FLP_RESP_OK;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= {I_AWADDR[7:2], 2'b00};
			end
			if (I_WVALID && O_WREADY) begin
				w_have_ff <= 1'b1;
				wdata_ff <= I_WDATA;
				wstrb_ff <= I_WSTRB;
			end
			if (wr_go) begin
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? `FLP_RESP_OK : `FLP_RESP_ERR;
			end else if (bvalid_ff && I_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign O_BVALID = bvalid_ff;
	assign O_BRESP = bresp_ff;
	assign ack_wr = wr_go && awaddr_ff == `FLP_A_ACK;
	assign reti_wr = wr_go && awaddr_ff == `FLP_A_RETI;
	function automatic logic wsel(input logic [7:0] a);
		wsel = wr_go && awaddr_ff == a;
	endfunction : wsel

	////////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			global_irq_enable_ff <= 1'b0;
			powerfail_irq_enable_ff <= 1'b0;
			ext0_edge_ff <= 1'b0;
			ext1_edge_ff <= 1'b0;
			ie_ff <= 8'h00;
			ext_irq_enable_reg_ff <= 8'h00;
			priority_low_bits_ff <= 8'h00;
			priority_high_bits_ff <= 8'h00;
			ext_priority_low_bits_ff <= 5'h00;
			ext_priority_high_bits_ff <= 5'h00;
			evt_enable_ff <= 2'b00;
		end else begin
			if (wsel(`FLP_A_CTRL)) begin
				global_irq_enable_ff <= wd[0];
				powerfail_irq_enable_ff <= wd[1];
				ext0_edge_ff <= wd[2];
				ext1_edge_ff <= wd[3];
			end
			if (wsel(`FLP_A_IE)) ie_ff <= wd[7:0];
			if (wsel(`FLP_A_EIE)) ext_irq_enable_reg_ff <= {3'b000, wd[4:0]};
			if (wsel(`FLP_A_PLO)) priority_low_bits_ff <= {1'b0, wd[6:0]};
			if (wsel(`FLP_A_PHI)) priority_high_bits_ff <= {1'b0, wd[6:0]};
			if (wsel(`FLP_A_EPLO)) ext_priority_low_bits_ff <= wd[4:0];
			if (wsel(`FLP_A_EPHI)) ext_priority_high_bits_ff <= wd[4:0];
			if (wsel(`FLP_A_EVEN)) evt_enable_ff <= wd[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request flags
	logic [NSRC-1:0] req, en, hi_bits, lo_bits;
	logic win_valid;
	logic [3:0] win_idx;
	flp_level_t win_level;
	logic [31:0] fclr;
	logic take;
	logic ext0_fall, ext1_fall;
	assign fclr = (wr_go && awaddr_ff == `FLP_A_FCLR) ? wd : 32'h0;
	assign take = ack_wr && irq_req_ff;
	assign ext0_fall = ext0_pin_d_ff && !I_EXT0_PIN_N;
	assign ext1_fall = ext1_pin_d_ff && !I_EXT1_PIN_N;
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			ext0_pin_d_ff <= 1'b1;
			ext1_pin_d_ff <= 1'b1;
		end else begin
			ext0_pin_d_ff <= I_EXT0_PIN_N;
			ext1_pin_d_ff <= I_EXT1_PIN_N;
		end
	end
	// Set wins over clear everywhere
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			powerfail_flag_ff <= 1'b0;
			ext0_flag_ff <= 1'b0;
			ext1_flag_ff <= 1'b0;
			tmr0_overflow_flag_ff <= 1'b0;
			tmr1_overflow_flag_ff <= 1'b0;
			tmr2_overflow_flag_ff <= 1'b0;
			tmr2_external_flag_ff <= 1'b0;
			ser0_receive_flag_ff <= 1'b0;
			ser0_transmit_flag_ff <= 1'b0;
			ser1_receive_flag_ff <= 1'b0;
			ser1_transmit_flag_ff <= 1'b0;
			ext25_flag_ff <= 4'h0;
			wdog_irq_flag_ff <= 1'b0;
		end else begin
			powerfail_flag_ff <= I_POWERFAIL_EVT | (powerfail_flag_ff & ~fclr[0]);
			if (ext0_edge_ff) begin
				ext0_flag_ff <= ext0_fall | (ext0_flag_ff & ~fclr[1] & ~(take && irq_vector_ff == `FLP_VEC_X0));
			end else begin
				ext0_flag_ff <= !I_EXT0_PIN_N;
			end
			if (ext1_edge_ff) begin
				ext1_flag_ff <= ext1_fall | (ext1_flag_ff & ~fclr[3] & ~(take && irq_vector_ff == `FLP_VEC_X1));
			end else begin
				ext1_flag_ff <= !I_EXT1_PIN_N;
			end
			tmr0_overflow_flag_ff <= I_TMR0_OVF | (tmr0_overflow_flag_ff & ~fclr[2] &
				~(take && irq_vector_ff == `FLP_VEC_T0));
			tmr1_overflow_flag_ff <= I_TMR1_OVF | (tmr1_overflow_flag_ff & ~fclr[4] &
				~(take && irq_vector_ff == `FLP_VEC_T1));
			ser0_receive_flag_ff <= I_SER0_RX | (ser0_receive_flag_ff & ~fclr[5]);
			ser0_transmit_flag_ff <= I_SER0_TX | (ser0_transmit_flag_ff & ~fclr[13]);
			tmr2_overflow_flag_ff <= I_TMR2_OVF | (tmr2_overflow_flag_ff & ~fclr[6]);
			tmr2_external_flag_ff <= I_TMR2_EXT | (tmr2_external_flag_ff & ~fclr[14]);
			ser1_receive_flag_ff <= I_SER1_RX | (ser1_receive_flag_ff & ~fclr[7]);
			ser1_transmit_flag_ff <= I_SER1_TX | (ser1_transmit_flag_ff & ~fclr[15]);
			ext25_flag_ff <= I_EXT25_EVT | (ext25_flag_ff & ~fclr[11:8]);
			wdog_irq_flag_ff <= I_WDOG_EVT | (wdog_irq_flag_ff & ~fclr[12]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gating and arbitration
	logic [NSRC-1:0] flags;
	assign flags = {wdog_irq_flag_ff, ext25_flag_ff, ser1_receive_flag_ff | ser1_transmit_flag_ff,
		tmr2_overflow_flag_ff | tmr2_external_flag_ff, ser0_receive_flag_ff | ser0_transmit_flag_ff,
		tmr1_overflow_flag_ff, ext1_flag_ff, tmr0_overflow_flag_ff, ext0_flag_ff, powerfail_flag_ff};
	assign en = {{ext_irq_enable_reg_ff[4:0], ie_ff[6:0]} & {12{global_irq_enable_ff}}, powerfail_irq_enable_ff};
	assign hi_bits = {ext_priority_high_bits_ff, priority_high_bits_ff[6:0], 1'b0};
	assign lo_bits = {ext_priority_low_bits_ff, priority_low_bits_ff[6:0], 1'b0};

	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_req
			assign req[g] = flags[g] & en[g];
		end
	endgenerate

	flp_arbiter #(.NSRC(NSRC)) u_arb (
		.i_req(req),
		.i_hi_bits(hi_bits),
		.i_lo_bits(lo_bits),
		.o_valid(win_valid),
		.o_idx(win_idx),
		.o_level(win_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Preemption and vector
	localparam logic [8*NSRC-1:0] VEC = `FLP_VEC_TABLE;
	logic [2:0] cur_level;
	logic cur_any;
	always_comb begin
		cur_any = 1'b0;
		cur_level = `FLP_LVL_NONE;
		for (int l = 0; l < 5; l++) begin
			if (active_ff[l]) begin
				cur_any = 1'b1;
				cur_level = l[2:0];
			end
		end
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			irq_req_ff <= 1'b0;
			irq_vector_ff <= 8'h00;
			irq_level_ff <= `FLP_LVL_NONE;
		end else if (!take) begin
			irq_req_ff <= win_valid && (!cur_any || win_level > cur_level);
			irq_vector_ff <= VEC[8*win_idx +: 8];
			irq_level_ff <= win_level;
		end else begin
			irq_req_ff <= 1'b0;
		end
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			active_ff <= 5'h00;
		end else if (take) begin
			active_ff <= active_ff | (5'h01 << irq_level_ff);
		end else if (reti_wr && cur_any) begin
			active_ff <= active_ff & ~(5'h01 << cur_level);
		end
	end
	assign O_IRQ_REQ = irq_req_ff;
	assign O_IRQ_VECTOR = irq_vector_ff;
	assign O_IRQ_LEVEL = irq_level_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Event status: bit0 acceptance, bit1 rejected acknowledge
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			evt_status_ff <= 2'b00;
		end else begin
			evt_status_ff <= {ack_wr && !irq_req_ff, take} | (evt_status_ff & ~(wsel(`FLP_A_EVCLR) ? wd[1:0] : 2'b00));
		end
	end
	assign O_EVT_IRQ = |(evt_status_ff & evt_enable_ff);

	////////////////////////////////////////////////////////////////////////////////
	// AXI read channel
	logic [31:0] rd_mux;
	logic rd_ok;
	assign O_ARREADY = !rvalid_ff;
	assign rd_go = I_ARVALID && !rvalid_ff;
	always_comb begin
		rd_ok = 1'b1;
		unique case ({I_ARADDR[7:2], 2'b00})
			`FLP_A_CTRL: rd_mux = {28'h0, ext1_edge_ff, ext0_edge_ff, powerfail_irq_enable_ff, global_irq_enable_ff};
			`FLP_A_IE: rd_mux = {24'h0, ie_ff};
			`FLP_A_EIE: rd_mux = {24'h0, ext_irq_enable_reg_ff};
			`FLP_A_PLO: rd_mux = {24'h0, priority_low_bits_ff};
			`FLP_A_PHI: rd_mux = {24'h0, priority_high_bits_ff};
			`FLP_A_EPLO: rd_mux = {27'h0, ext_priority_low_bits_ff};
			`FLP_A_EPHI: rd_mux = {27'h0, ext_priority_high_bits_ff};
			`FLP_A_FLAGS: rd_mux = {16'h0, ser1_transmit_flag_ff, tmr2_external_flag_ff, ser0_transmit_flag_ff,
				wdog_irq_flag_ff, ext25_flag_ff, ser1_receive_flag_ff, tmr2_overflow_flag_ff, ser0_receive_flag_ff,
				tmr1_overflow_flag_ff, ext1_flag_ff, tmr0_overflow_flag_ff, ext0_flag_ff, powerfail_flag_ff};
			`FLP_A_STAT: rd_mux = {11'h0, active_ff, irq_level_ff, irq_vector_ff, 4'h0, irq_req_ff};
			`FLP_A_EVST: rd_mux = {30'h0, evt_status_ff};
			`FLP_A_EVEN: rd_mux = {30'h0, evt_enable_ff};
			`FLP_A_FCLR, `FLP_A_ACK, `FLP_A_RETI, `FLP_A_EVCLR: rd_mux = 32'h0;
			default: begin
				rd_mux = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= `FLP_RESP_OK;
			araddr_ff <= 8'h00;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_ok ? `FLP_RESP_OK : `FLP_RESP_ERR;
			araddr_ff <= I_ARADDR;
		end else if (rvalid_ff && I_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign O_RVALID = rvalid_ff;
	assign O_RDATA = rdata_ff;
	assign O_RRESP = rresp_ff;
endmodule : flp_intc

// ### design/flp_pkg.sv
// Types for the five-level interrupt prioritizer
package flp_pkg;
	typedef logic [2:0] flp_level_t;
	typedef logic [7:0] flp_vector_t;
endpackage : flp_pkg

// ### verification/flp_chk.sv
// Port checker for the interrupt prioritizer
module flp_chk (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Core side
	input wire logic O_IRQ_REQ,
	input wire logic [7:0] O_IRQ_VECTOR,
	input wire logic [2:0] O_IRQ_LEVEL,
	// Register bus
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic [1:0] O_BRESP,
	input wire logic I_BREADY,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic [31:0] O_RDATA,
	input wire logic I_RREADY
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	////////////////////////////////////////////////////////////////
	property p_bv_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
	a_bv_hold: assert property (p_bv_hold) else $error("write response dropped early");
	property p_rv_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
	a_rv_hold: assert property (p_rv_hold) else $error("read data dropped early");
	property p_ar_busy; O_RVALID |-> !O_ARREADY; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
	property p_aw_busy; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
	property p_rd_ans; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	// Both halves are latched first, the response is registered one cycle after that
	property p_wr_ans; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	////////////////////////////////////////////////////////////////
	property p_pf_top; O_IRQ_REQ && O_IRQ_VECTOR == 8'h33 |-> O_IRQ_LEVEL == 3'd4; endproperty
	a_pf_top: assert property (p_pf_top) else $error("power-fail not at top level");
	property p_top_pf; O_IRQ_REQ && O_IRQ_LEVEL == 3'd4 |-> O_IRQ_VECTOR == 8'h33; endproperty
	a_top_pf: assert property (p_top_pf) else $error("top level not power-fail");
	property p_lvl; O_IRQ_REQ && O_IRQ_VECTOR != 8'h33 |-> O_IRQ_LEVEL <= 3'd3; endproperty
	a_lvl: assert property (p_lvl) else $error("level out of range");
	property p_vec; O_IRQ_REQ |-> O_IRQ_VECTOR[2:0] == 3'd3 && O_IRQ_VECTOR <= 8'h63; endproperty
	a_vec: assert property (p_vec) else $error("vector not in table");
endmodule : flp_chk

// ### verification/flp_src_model.sv
// Source-side model: peripheral events and external pins
module flp_src_model (
	// Clock
	input wire logic i_clk,
	// Bench control
	input wire logic i_fire,
	input wire logic [12:0] i_mask,
	input wire logic [2:0] i_alt,
	input wire logic i_hold0,
	// Events in flag layout, pins
	output logic [15:0] o_evt,
	output logic o_x0_n,
	output logic o_x1_n
);
	logic [12:0] pulse_ff = '0;
	always_ff @(posedge i_clk) begin
		pulse_ff <= i_fire ? i_mask : 13'h0;
	end
	// Second flag of a shared source chosen by alt
	assign o_evt = {pulse_ff[7] & i_alt[2], pulse_ff[6] & i_alt[1], pulse_ff[5] & i_alt[0], pulse_ff[12:8],
		pulse_ff[7] & !i_alt[2], pulse_ff[6] & !i_alt[1], pulse_ff[5] & !i_alt[0], pulse_ff[4:0]};
	// Pins idle high, one-cycle low pulse; only o_x0_n can also be held low, by i_hold0
	assign o_x0_n = !(pulse_ff[1] || i_hold0);
	assign o_x1_n = !pulse_ff[3];
endmodule : flp_src_model

// ### verification/tb_five_level_interrupt_prioritizer.sv
// Self-checking bench for the interrupt prioritizer
module tb_five_level_interrupt_prioritizer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] VEC [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b,
		8'h53, 8'h5b, 8'h63};
	logic clk = 0, rst_n = 0, fire = 0, hold0 = 0, ge, pfe;
	logic [12:0] mask = 0, m;
	logic [2:0] alt = 0, lvl;
	logic [15:0] evt;
	logic x0_n, x1_n, irq, evt_irq, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] vec, awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [1:0] bresp, rresp, rsp;
	logic [11:0] ie, lo, hi;
	int seed = 32'hd1f3dd5c;
	int miscompares = 0, n_tests = 0, cyc = 0;
	////////////////////////////////////////////////////////////////
	flp_src_model u_src (.i_clk(clk), .i_fire(fire), .i_mask(mask), .i_alt(alt), .i_hold0(hold0),
		.o_evt(evt), .o_x0_n(x0_n), .o_x1_n(x1_n));
	flp_intc dut (.I_CLK(clk), .I_RST_N(rst_n), .I_POWERFAIL_EVT(evt[0]), .I_EXT0_PIN_N(x0_n),
		.I_EXT1_PIN_N(x1_n), .I_TMR0_OVF(evt[2]), .I_TMR1_OVF(evt[4]), .I_TMR2_OVF(evt[6]),
		.I_TMR2_EXT(evt[14]), .I_SER0_RX(evt[5]), .I_SER0_TX(evt[13]), .I_SER1_RX(evt[7]),
		.I_SER1_TX(evt[15]), .I_EXT25_EVT(evt[11:8]), .I_WDOG_EVT(evt[12]), .O_IRQ_REQ(irq),
		.O_IRQ_VECTOR(vec), .O_IRQ_LEVEL(lvl), .O_EVT_IRQ(evt_irq), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready),
		.O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
	////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
		end while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 0;
	endtask : rdr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic fire_src(input logic [12:0] mm);
		@(posedge clk);
		fire <= 1;
		mask <= mm;
		@(posedge clk);
		fire <= 0;
		repeat (4) @(posedge clk);
	endtask : fire_src
	task automatic results();
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	function automatic logic [31:0] exp_flags(input logic [12:0] mm, input logic [2:0] a);
		logic [31:0] f;
		f = 32'(mm);
		for (int k = 0; k < 3; k++) if (a[k] && mm[5+k]) f = f ^ (32'h2020 << k);
		return f;
	endfunction : exp_flags
	function automatic logic [11:0] exp_win(input logic [12:0] mm, input logic g, pe, input logic [11:0] e, l0, h1);
		logic v, en;
		logic [2:0] l, bl;
		logic [7:0] bv;
		v = 0;
		bl = 0;
		bv = 0;
		for (int i = 0; i < 13; i++) begin
			en = (i == 0) ? pe : g && e[i-1];
			l = (i == 0) ? 3'd4 : {1'b0, h1[i-1], l0[i-1]};
			if (mm[i] && en && (!v || l > bl)) begin
				v = 1;
				bl = l;
				bv = VEC[i];
			end
		end
		return {v, bl, bv};
	endfunction : exp_win
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rdr(8'h00);
		chk(rd, 0);
		rdr(8'h1c);
		chk(rd, 0);
		rdr(8'hfc);
		chk(rsp, 2'b10);
		wr(8'hfc, 1);
		chk(rsp, 2'b10);
		for (int it = 0; it < 40; it++) begin
			{ge, pfe} = 2'($random(seed));
			ie = 12'($random(seed));
			lo = 12'($random(seed));
			hi = 12'($random(seed));
			m = 13'($random(seed));
			alt <= 3'($random(seed));
			if (it == 0) {ge, pfe, ie, lo, hi, m} = {2'b11, 12'hfff, 24'h0, 13'h1ffe};
			if (it == 1) {ge, pfe, m} = {2'b01, 13'h1fff};
			wr(8'h00, {28'h0, 2'b11, pfe, ge});
			wr(8'h04, 32'(ie[6:0]));
			wr(8'h08, 32'(ie[11:7]));
			wr(8'h0c, 32'(lo[6:0]));
			wr(8'h10, 32'(hi[6:0]));
			wr(8'h14, 32'(lo[11:7]));
			wr(8'h18, 32'(hi[11:7]));
			fire_src(m);
			chk({irq, irq ? {lvl, vec} : 11'h0}, exp_win(m, ge, pfe, ie, lo, hi));
			rdr(8'h1c);
			chk(rd, exp_flags(m, alt));
			wr(8'h20, 32'hffff);
		end
		wr(8'h00, 32'hf);
		wr(8'h04, 32'h7f);
		wr(8'h08, 0);
		wr(8'h0c, 32'h12);
		wr(8'h10, 32'h40);
		alt <= 0;
		fire_src(13'h4);
		chk({irq, vec}, {1'b1, 8'h0b});
		wr(8'h28, 0);
		rdr(8'h1c);
		chk(rd, 0);
		fire_src(13'h20);
		chk(irq, 0);
		fire_src(13'h80);
		chk({irq, lvl, vec}, {1'b1, 3'd2, 8'h3b});
		wr(8'h28, 0);
		fire_src(13'h1);
		chk({irq, lvl, vec}, {1'b1, 3'd4, 8'h33});
		wr(8'h28, 0);
		rdr(8'h1c);
		chk(rd, 32'ha1);
		repeat (3) wr(8'h2c, 0);
		wr(8'h20, 32'hffff);
		fire_src(13'h2);
		chk(vec, 8'h03);
		wr(8'h28, 0);
		rdr(8'h1c);
		chk(rd, 0);
		wr(8'h2c, 0);
		wr(8'h00, 32'h3);
		hold0 <= 1;
		repeat (3) @(posedge clk);
		rdr(8'h1c);
		chk(rd[1], 1);
		hold0 <= 0;
		repeat (3) @(posedge clk);
		rdr(8'h1c);
		chk(rd[1], 0);
		wr(8'h28, 0);
		rdr(8'h30);
		chk(rd, 3);
		chk(evt_irq, 0);
		wr(8'h38, 3);
		chk(evt_irq, 1);
		wr(8'h34, 3);
		chk(evt_irq, 0);
		rdr(8'h30);
		chk(rd, 0);
		results();
	end
endmodule : tb_five_level_interrupt_prioritizer
bind flp_intc flp_chk u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .O_IRQ_REQ(O_IRQ_REQ), .O_IRQ_VECTOR(O_IRQ_VECTOR),
	.O_IRQ_LEVEL(O_IRQ_LEVEL), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
	.O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
	.O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .I_RREADY(I_RREADY));
